// file: rtl/spm_pkg.sv
`default_nettype none
package spm_pkg;
    // ------------------------------------------------------------
    // mode field and partition state encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_FIELD_DISABLED = 2'h0;
    localparam logic [1:0] MODE_FIELD_UNATTACHED = 2'h1;
    localparam logic [1:0] MODE_FIELD_UPSTREAM = 2'h2;
    localparam logic [1:0] MODE_FIELD_DOWNSTREAM = 2'h3;
    localparam logic [1:0] PART_STATE_DISABLED = 2'h0;
    localparam logic [1:0] PART_STATE_FRESET = 2'h1;
    localparam logic [1:0] PART_STATE_ACTIVE = 2'h2;
    localparam int NPART = 8;
    localparam int PSEL_W = 3;
    // ------------------------------------------------------------
    // port register file
    // ------------------------------------------------------------
    localparam int REG_COUNT = 8;
    localparam int REG_IDX_W = 3;
    localparam logic [2:0] STATUS_IDX = 3'h0;
    localparam logic [31:0] REG_RESET = 32'h0;
    localparam int STS_MODE_LSB = 0;
    localparam int STS_MERGED_BIT = 2;
    localparam int STS_PWR_ON_BIT = 3;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int LANE_WAKE_NS = 1000;
    localparam logic [3:0] WAKE_CYC =
        4'((LANE_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SPM_DISABLED, SPM_UNATTACHED, SPM_UPSTREAM, SPM_DOWNSTREAM
    } spm_mode_e;
    typedef enum logic [1:0] {PWR_ON, PWR_OFF, PWR_WAKE} spm_pwr_e;
    typedef struct packed {
        logic attention;
        logic interlock;
        logic power_en;
        logic power_ind;
        logic reset_n;
    } spm_hp_out_s;
    typedef struct packed {
        logic button_n;
        logic latch_n;
        logic presence_n;
        logic fault_n;
        logic pgood_n;
    } spm_hp_in_s;
    typedef struct packed {
        logic pm;
        logic intx;
        logic msi;
        logic err;
    } spm_msg_s;
    localparam spm_hp_out_s HP_NEGATED = '{attention: 1'b0,
        interlock: 1'b0, power_en: 1'b0, power_ind: 1'b0, reset_n: 1'b0};
    localparam spm_hp_in_s HP_IN_IDLE = '{button_n: 1'b1, latch_n: 1'b1,
        presence_n: 1'b1, fault_n: 1'b1, pgood_n: 1'b1};
endpackage
`default_nettype wire

// file: rtl/spm_port_mode.sv
`default_nettype none
module spm_port_mode (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // mode selection
    input wire logic [1:0] per_port_control_mode,
    input wire logic [spm_pkg::PSEL_W-1:0] port_partition_select,
    input wire logic [spm_pkg::NPART-1:0][1:0] partition_state,
    input wire logic [spm_pkg::NPART-1:0] partition_fundamental_reset_n,
    input wire logic port_pair_merge_strap_n,
    // core side requests
    input wire spm_pkg::spm_msg_s msg_req,
    input wire spm_pkg::spm_hp_out_s hp_ctrl,
    input wire logic link_active,
    input wire logic link_up,
    // slot pins
    input wire spm_pkg::spm_hp_in_s slot_in,
    output spm_pkg::spm_hp_out_s slot_out,
    output logic port_activity_indicator_n,
    output logic port_link_up_indicator_n,
    // core side results
    output spm_pkg::spm_msg_s msg_out,
    output spm_pkg::spm_hp_in_s hp_in_seen,
    output logic port_part_reset,
    output logic port_merged,
    output logic port_logic_en,
    output logic link_role_upstream,
    output logic bridge_downstream_layout,
    output logic [1:0] eff_mode,
    // link and lane power
    output logic ltssm_force_detect,
    output logic ltssm_hold,
    output logic lane_power_en,
    output logic port_clk_en,
    // global address space access
    input wire logic gas_valid,
    input wire logic gas_wr,
    input wire logic [spm_pkg::REG_IDX_W-1:0] gas_addr,
    input wire logic [31:0] gas_wdata,
    output logic gas_ack,
    output logic [31:0] gas_rdata,
    // configuration requests received over the link
    input wire logic lnk_cfg_valid,
    input wire logic lnk_cfg_wr,
    input wire logic [spm_pkg::REG_IDX_W-1:0] lnk_cfg_addr,
    input wire logic [31:0] lnk_cfg_wdata,
    output logic lnk_cfg_done,
    output logic lnk_cfg_retry,
    output logic [31:0] lnk_cfg_rdata
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n_int;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_n_int <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n_int <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    spm_pkg::spm_mode_e cur_mode;
    spm_pkg::spm_pwr_e pwr_state;
    logic [3:0] wake_cnt;
    logic strap_done;
    logic [31:0] regs [spm_pkg::REG_COUNT];
    logic is_dis;
    logic attached;

    function automatic logic is_oper(input spm_pkg::spm_mode_e m);
        is_oper = (m == spm_pkg::SPM_UPSTREAM) ||
            (m == spm_pkg::SPM_DOWNSTREAM);
    endfunction

    function automatic spm_pkg::spm_mode_e decode_mode(
        input logic [1:0] f, input logic [1:0] ps);
        spm_pkg::spm_mode_e m;
        m = spm_pkg::SPM_DISABLED;
        unique case (f)
            spm_pkg::MODE_FIELD_DISABLED: m = spm_pkg::SPM_DISABLED;
            spm_pkg::MODE_FIELD_UNATTACHED: m = spm_pkg::SPM_UNATTACHED;
            spm_pkg::MODE_FIELD_UPSTREAM: m = spm_pkg::SPM_UPSTREAM;
            spm_pkg::MODE_FIELD_DOWNSTREAM: m = spm_pkg::SPM_DOWNSTREAM;
        endcase
        // partition override only hits attached modes
        if (is_oper(m) && ps == spm_pkg::PART_STATE_DISABLED) begin
            m = spm_pkg::SPM_DISABLED;
        end
        decode_mode = m;
    endfunction

    function automatic logic [31:0] read_reg(
        input logic [spm_pkg::REG_IDX_W-1:0] idx);
        logic [31:0] v;
        v = regs[idx];
        if (idx == spm_pkg::STATUS_IDX) begin
            v = 32'h0;
            v[spm_pkg::STS_MODE_LSB +: 2] = cur_mode;
            v[spm_pkg::STS_MERGED_BIT] = port_merged;
            v[spm_pkg::STS_PWR_ON_BIT] = (pwr_state == spm_pkg::PWR_ON);
        end
        read_reg = v;
    endfunction

    assign is_dis = (cur_mode == spm_pkg::SPM_DISABLED);
    assign attached = is_oper(cur_mode);

    // ------------------------------------------------------------
    // mode selection
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            cur_mode <= spm_pkg::SPM_DISABLED;
        end else begin
            cur_mode <= decode_mode(per_port_control_mode,
                partition_state[port_partition_select]);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            eff_mode <= 2'h0;
            link_role_upstream <= 1'b0;
            bridge_downstream_layout <= 1'b1;
            port_logic_en <= 1'b0;
        end else begin
            eff_mode <= cur_mode;
            link_role_upstream <= (cur_mode == spm_pkg::SPM_UNATTACHED) ||
                (cur_mode == spm_pkg::SPM_UPSTREAM);
            bridge_downstream_layout <= is_dis ||
                (cur_mode == spm_pkg::SPM_DOWNSTREAM);
            port_logic_en <= !is_dis;
        end
    end

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    // taken once just after release; later pin motion is ignored
    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            strap_done <= 1'b0;
            port_merged <= 1'b0;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            port_merged <= !port_pair_merge_strap_n;
        end
    end

    // ------------------------------------------------------------
    // output negation and input masking
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            msg_out <= '0;
            slot_out <= spm_pkg::HP_NEGATED;
            port_activity_indicator_n <= 1'b1;
            port_link_up_indicator_n <= 1'b1;
        end else if (is_dis) begin
            msg_out <= '0;
            slot_out <= spm_pkg::HP_NEGATED;
            port_activity_indicator_n <= 1'b1;
            port_link_up_indicator_n <= 1'b1;
        end else begin
            msg_out <= msg_req;
            slot_out <= hp_ctrl;
            port_activity_indicator_n <= !link_active;
            port_link_up_indicator_n <= !link_up;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            hp_in_seen <= spm_pkg::HP_IN_IDLE;
            port_part_reset <= 1'b0;
        end else begin
            hp_in_seen <= is_dis ? spm_pkg::HP_IN_IDLE : slot_in;
            // unattached ports see no partition at all
            port_part_reset <= attached &&
                !partition_fundamental_reset_n[port_partition_select];
        end
    end

    // ------------------------------------------------------------
    // lane power and ltssm control
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            pwr_state <= spm_pkg::PWR_OFF;
            wake_cnt <= 4'h0;
            ltssm_force_detect <= 1'b1;
            ltssm_hold <= 1'b1;
            lane_power_en <= 1'b0;
            port_clk_en <= 1'b0;
        end else begin
            unique case (pwr_state)
                spm_pkg::PWR_ON: begin
                    if (is_dis) begin
                        pwr_state <= spm_pkg::PWR_OFF;
                        ltssm_force_detect <= 1'b1;
                        ltssm_hold <= 1'b1;
                        lane_power_en <= 1'b0;
                        port_clk_en <= 1'b0;
                    end
                end
                spm_pkg::PWR_OFF: begin
                    if (!is_dis) begin
                        pwr_state <= spm_pkg::PWR_WAKE;
                        wake_cnt <= 4'h0;
                        lane_power_en <= 1'b1;
                        port_clk_en <= 1'b1;
                    end
                end
                spm_pkg::PWR_WAKE: begin
                    if (is_dis) begin
                        pwr_state <= spm_pkg::PWR_OFF;
                        lane_power_en <= 1'b0;
                        port_clk_en <= 1'b0;
                    end else if (wake_cnt == spm_pkg::WAKE_CYC - 4'h1) begin
                        // lanes settle before training may start
                        pwr_state <= spm_pkg::PWR_ON;
                        ltssm_force_detect <= 1'b0;
                        ltssm_hold <= 1'b0;
                    end else begin
                        wake_cnt <= wake_cnt + 4'h1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // port registers
    // ------------------------------------------------------------
    logic lnk_ok;
    assign lnk_ok = lnk_cfg_valid && !is_dis;

    // contents survive every mode change; only status is live
    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            for (int i = 0; i < spm_pkg::REG_COUNT; i++) begin
                regs[i] <= spm_pkg::REG_RESET;
            end
        end else if (gas_valid && gas_wr &&
                     gas_addr != spm_pkg::STATUS_IDX) begin
            regs[gas_addr] <= gas_wdata;
        end else if (lnk_ok && lnk_cfg_wr &&
                     lnk_cfg_addr != spm_pkg::STATUS_IDX) begin
            regs[lnk_cfg_addr] <= lnk_cfg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            gas_ack <= 1'b0;
            gas_rdata <= 32'h0;
            lnk_cfg_done <= 1'b0;
            lnk_cfg_retry <= 1'b0;
            lnk_cfg_rdata <= 32'h0;
        end else begin
            gas_ack <= gas_valid;
            gas_rdata <= gas_valid ? read_reg(gas_addr) : 32'h0;
            lnk_cfg_done <= lnk_ok;
            lnk_cfg_retry <= lnk_cfg_valid && is_dis;
            lnk_cfg_rdata <= lnk_ok ? read_reg(lnk_cfg_addr) : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_wake_ready;
        lane_power_en && port_clk_en ##1 lane_power_en && port_clk_en;
    endsequence

    property p_msg_quiet;
        @(posedge core_clk) disable iff (!rst_n_int)
        is_dis |=> msg_out == '0;
    endproperty
    a_msg_quiet: assert property (p_msg_quiet)
        else $error("message left a disabled port");

    property p_hp_negated;
        @(posedge core_clk) disable iff (!rst_n_int)
        is_dis |=> slot_out == spm_pkg::HP_NEGATED;
    endproperty
    a_hp_negated: assert property (p_hp_negated)
        else $error("slot output active while disabled");

    property p_ind_off;
        @(posedge core_clk) disable iff (!rst_n_int)
        is_dis |=> port_activity_indicator_n && port_link_up_indicator_n;
    endproperty
    a_ind_off: assert property (p_ind_off)
        else $error("indicator lit while disabled");

    property p_in_ignored;
        @(posedge core_clk) disable iff (!rst_n_int)
        is_dis |=> hp_in_seen == spm_pkg::HP_IN_IDLE;
    endproperty
    a_in_ignored: assert property (p_in_ignored)
        else $error("slot input passed while disabled");

    property p_strap_stable;
        @(posedge core_clk) disable iff (!rst_n_int)
        strap_done |=> $stable(port_merged);
    endproperty
    a_strap_stable: assert property (p_strap_stable)
        else $error("merge state moved after reset");

    property p_part_isolated;
        @(posedge core_clk) disable iff (!rst_n_int)
        !attached |=> !port_part_reset;
    endproperty
    a_part_isolated: assert property (p_part_isolated)
        else $error("partition reset reached unattached port");

    property p_detect_entry;
        @(posedge core_clk) disable iff (!rst_n_int)
        (is_dis && pwr_state == spm_pkg::PWR_ON) |=>
            ltssm_force_detect && !lane_power_en && !port_clk_en;
    endproperty
    a_detect_entry: assert property (p_detect_entry)
        else $error("disable entry left lanes or clock on");

    property p_wake_order;
        @(posedge core_clk) disable iff (!rst_n_int)
        s_wake_ready ##1 $fell(ltssm_hold) |-> lane_power_en;
    endproperty
    a_wake_order: assert property (p_wake_order)
        else $error("training released before lanes powered");

    property p_hold_needs_power;
        @(posedge core_clk) disable iff (!rst_n_int)
        $fell(ltssm_hold) |-> $past(lane_power_en, 2) && port_clk_en;
    endproperty
    a_hold_needs_power: assert property (p_hold_needs_power)
        else $error("wake time too short");

    property p_cfg_refused;
        @(posedge core_clk) disable iff (!rst_n_int)
        (lnk_cfg_valid && is_dis) |=> lnk_cfg_retry && !lnk_cfg_done;
    endproperty
    a_cfg_refused: assert property (p_cfg_refused)
        else $error("link config accepted while disabled");

    property p_gas_ack;
        @(posedge core_clk) disable iff (!rst_n_int)
        gas_valid |=> gas_ack;
    endproperty
    a_gas_ack: assert property (p_gas_ack)
        else $error("global access not answered");

    property p_part_override;
        @(posedge core_clk) disable iff (!rst_n_int)
        partition_state[port_partition_select] ==
            spm_pkg::PART_STATE_DISABLED |=> !attached;
    endproperty
    a_part_override: assert property (p_part_override)
        else $error("port attached to disabled partition");

    property p_unatt_ind;
        @(posedge core_clk) disable iff (!rst_n_int)
        (cur_mode == spm_pkg::SPM_UNATTACHED && link_up) |=>
            !port_link_up_indicator_n;
    endproperty
    a_unatt_ind: assert property (p_unatt_ind)
        else $error("unattached link-up indicator wrong");
endmodule // spm_port_mode
`default_nettype wire

// file: testbench/spm_link_partner.sv
`default_nettype none
module spm_link_partner (
    // clock
    input wire logic core_clk,
    // bench commands and lane state
    input wire logic train,
    input wire logic lane_power_en,
    input wire logic ltssm_hold,
    input wire spm_pkg::spm_hp_in_s slot_cmd,
    // towards the port
    output spm_pkg::spm_hp_in_s slot_in,
    output logic link_up,
    output logic link_active
);
    // ------------------------------------------------------------
    // link training
    // ------------------------------------------------------------
    logic [1:0] train_cnt;
    // no training without powered lanes and a released state machine
    always_ff @(posedge core_clk) begin
        if (!(train && lane_power_en && !ltssm_hold)) begin
            train_cnt <= 2'h0;
        end else if (train_cnt != 2'h2) begin
            train_cnt <= train_cnt + 2'h1;
        end
    end
    assign link_up = (train_cnt == 2'h2);
    assign link_active = link_up;
    assign slot_in = slot_cmd;
endmodule // spm_link_partner
`default_nettype wire

// file: testbench/spm_port_mode_tb_top.sv
`default_nettype none
module spm_port_mode_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic core_clk, rst_b, train, link_active, link_up;
    logic [1:0] per_port_control_mode, eff_mode;
    logic [2:0] port_partition_select, gas_addr, lnk_cfg_addr;
    logic [7:0][1:0] partition_state;
    logic [7:0] partition_fundamental_reset_n;
    logic port_pair_merge_strap_n, port_activity_indicator_n;
    logic port_link_up_indicator_n, port_part_reset, port_merged;
    logic port_logic_en, link_role_upstream, bridge_downstream_layout;
    logic ltssm_force_detect, ltssm_hold, lane_power_en, port_clk_en;
    logic gas_valid, gas_wr, gas_ack, lnk_cfg_valid, lnk_cfg_wr;
    logic lnk_cfg_done, lnk_cfg_retry;
    logic [31:0] gas_wdata, gas_rdata, lnk_cfg_wdata, lnk_cfg_rdata;
    spm_pkg::spm_msg_s msg_req, msg_out;
    spm_pkg::spm_hp_out_s hp_ctrl, slot_out;
    spm_pkg::spm_hp_in_s slot_in, slot_cmd, hp_in_seen;
    int mismatches, n_tests, n;
    spm_port_mode dut (
        .core_clk, .rst_b, .per_port_control_mode, .port_partition_select,
        .partition_state, .partition_fundamental_reset_n,
        .port_pair_merge_strap_n, .msg_req, .hp_ctrl, .link_active,
        .link_up, .slot_in, .slot_out, .port_activity_indicator_n,
        .port_link_up_indicator_n, .msg_out, .hp_in_seen, .port_part_reset,
        .port_merged, .port_logic_en, .link_role_upstream,
        .bridge_downstream_layout, .eff_mode, .ltssm_force_detect,
        .ltssm_hold, .lane_power_en, .port_clk_en, .gas_valid, .gas_wr,
        .gas_addr, .gas_wdata, .gas_ack, .gas_rdata, .lnk_cfg_valid,
        .lnk_cfg_wr, .lnk_cfg_addr, .lnk_cfg_wdata, .lnk_cfg_done,
        .lnk_cfg_retry, .lnk_cfg_rdata
    );
    spm_link_partner peer (
        .core_clk, .train, .lane_power_en, .ltssm_hold, .slot_cmd,
        .slot_in, .link_up, .link_active
    );
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic gas(input logic wr, input logic [2:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        gas_valid <= 1'b1;
        gas_wr <= wr;
        gas_addr <= a;
        gas_wdata <= d;
        @(posedge core_clk);
        gas_valid <= 1'b0;
        #1;
        chk("gas_ack", 32'(gas_ack), 32'h1);
        if (!wr) begin
            chk("gas_rdata", gas_rdata, d);
        end
    endtask
    task automatic lnk(input logic wr, input logic [2:0] a,
                       input logic [31:0] d, input logic ok);
        @(posedge core_clk);
        lnk_cfg_valid <= 1'b1;
        lnk_cfg_wr <= wr;
        lnk_cfg_addr <= a;
        lnk_cfg_wdata <= d;
        @(posedge core_clk);
        lnk_cfg_valid <= 1'b0;
        #1;
        chk("lnk_done", 32'(lnk_cfg_done), 32'(ok));
        chk("lnk_retry", 32'(lnk_cfg_retry), 32'(!ok));
        chk("lnk_rdata", lnk_cfg_rdata, (ok && !wr) ? d : 32'h0);
    endtask
    // lanes and clock must come back a full wake time before training
    task automatic wake();
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (lane_power_en !== 1'b1 && n < 20);
        chk("lanes_on", 32'(lane_power_en), 32'h1);
        if (n >= 20) begin
            results();
        end
        chk("hold_at_wake", 32'(ltssm_hold), 32'h1);
        n = 0;
        while (ltssm_hold !== 1'b0 && n < 20) begin
            cyc(1);
            n++;
        end
        chk("wake_cyc", 32'(n), 32'(spm_pkg::WAKE_CYC));
        if (n >= 20) begin
            results();
        end
        cyc(6);
    endtask
    task automatic dis_chk();
        chk("slot_out", 32'(slot_out), 32'(spm_pkg::HP_NEGATED));
        chk("act_n", 32'(port_activity_indicator_n), 32'h1);
        chk("lnkup_n", 32'(port_link_up_indicator_n), 32'h1);
        chk("msg_out", 32'(msg_out), 32'h0);
        chk("hp_seen", 32'(hp_in_seen), 32'(spm_pkg::HP_IN_IDLE));
        chk("part_rst", 32'(port_part_reset), 32'h0);
        chk("force_det", 32'(ltssm_force_detect), 32'h1);
        chk("lanes", 32'(lane_power_en), 32'h0);
        chk("clk_en", 32'(port_clk_en), 32'h0);
        chk("logic_en", 32'(port_logic_en), 32'h0);
        chk("bridge", 32'(bridge_downstream_layout), 32'h1);
        chk("eff_mode", 32'(eff_mode), 32'h0);
    endtask
    task automatic run_chk(input logic [1:0] em, input logic role, bds);
        chk("eff_mode", 32'(eff_mode), 32'(em));
        chk("role_up", 32'(link_role_upstream), 32'(role));
        chk("bridge", 32'(bridge_downstream_layout), 32'(bds));
        chk("act_n", 32'(port_activity_indicator_n), 32'h0);
        chk("lnkup_n", 32'(port_link_up_indicator_n), 32'h0);
        chk("logic_en", 32'(port_logic_en), 32'h1);
        chk("force_det", 32'(ltssm_force_detect), 32'h0);
        chk("clk_en", 32'(port_clk_en), 32'h1);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        mismatches = 0;
        n_tests = 0;
        rst_b = 1'b0;
        train = 1'b1;
        per_port_control_mode = spm_pkg::MODE_FIELD_DISABLED;
        port_partition_select = 3'h5;
        partition_state = {8{spm_pkg::PART_STATE_ACTIVE}};
        partition_fundamental_reset_n = 8'hff;
        port_pair_merge_strap_n = 1'b0;
        msg_req = '1;
        hp_ctrl = '1;
        slot_cmd = '0;
        {gas_valid, gas_wr, lnk_cfg_valid, lnk_cfg_wr} = 4'h0;
        {gas_addr, lnk_cfg_addr, gas_wdata, lnk_cfg_wdata} = '0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        cyc(4);
        // strap moves after capture; partition reset asserted
        @(posedge core_clk);
        port_pair_merge_strap_n <= 1'b1;
        partition_fundamental_reset_n[5] <= 1'b0;
        cyc(4);
        dis_chk();
        chk("merged", 32'(port_merged), 32'h1);
        gas(1'b1, 3'h3, 32'ha5a5_5a5a);
        gas(1'b0, 3'h3, 32'ha5a5_5a5a);
        gas(1'b1, 3'h0, 32'hffff_ffff);
        gas(1'b0, 3'h0, 32'h0000_0004);
        lnk(1'b1, 3'h3, 32'h0000_0000, 1'b0);
        lnk(1'b0, 3'h3, 32'ha5a5_5a5a, 1'b0);
        gas(1'b0, 3'h3, 32'ha5a5_5a5a);
        $display("test disabled done");
        @(posedge core_clk);
        per_port_control_mode <= spm_pkg::MODE_FIELD_UPSTREAM;
        wake();
        run_chk(2'h2, 1'b1, 1'b0);
        chk("slot_out", 32'(slot_out), 32'(hp_ctrl));
        chk("msg_out", 32'(msg_out), 32'(msg_req));
        chk("hp_seen", 32'(hp_in_seen), 32'(slot_cmd));
        chk("part_rst", 32'(port_part_reset), 32'h1);
        chk("merged", 32'(port_merged), 32'h1);
        gas(1'b0, 3'h3, 32'ha5a5_5a5a);
        gas(1'b0, 3'h0, 32'h0000_000e);
        lnk(1'b1, 3'h4, 32'h1234_5678, 1'b1);
        lnk(1'b0, 3'h4, 32'h1234_5678, 1'b1);
        $display("test upstream done");
        @(posedge core_clk);
        partition_state[5] <= spm_pkg::PART_STATE_DISABLED;
        cyc(4);
        dis_chk();
        @(posedge core_clk);
        partition_state[5] <= spm_pkg::PART_STATE_ACTIVE;
        per_port_control_mode <= spm_pkg::MODE_FIELD_DOWNSTREAM;
        wake();
        run_chk(2'h3, 1'b0, 1'b1);
        @(posedge core_clk);
        per_port_control_mode <= spm_pkg::MODE_FIELD_UNATTACHED;
        cyc(6);
        run_chk(2'h1, 1'b1, 1'b0);
        chk("part_rst", 32'(port_part_reset), 32'h0);
        @(posedge core_clk);
        partition_state[5] <= spm_pkg::PART_STATE_DISABLED;
        cyc(4);
        chk("eff_mode", 32'(eff_mode), 32'h1);
        $display("test modes done");
        // second reset captures the now released strap
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        cyc(5);
        chk("merged", 32'(port_merged), 32'h0);
        $display("test strap done");
        results();
    end
endmodule // spm_port_mode_tb_top
`default_nettype wire
